// >>> hdl/sad_pkg.sv
// constants and types for the system address decoder
package sad_pkg;
    localparam int ADDR_W = 32;
    localparam int TGT_W = 4;
    localparam logic [31:0] DRAM_BASE = 32'h0000_0000;
    localparam logic [31:0] FAB0_BASE = 32'h4000_0000;
    localparam logic [31:0] FAB1_BASE = 32'h8000_0000;
    localparam logic [31:0] HOLE0_BASE = 32'hC000_0000;
    localparam logic [31:0] IO_BASE = 32'hE000_0000;
    localparam logic [31:0] RSV0_BASE = 32'hF000_0000;
    localparam logic [31:0] APB_BASE = 32'hF800_0000;
    localparam logic [31:0] RSV1_BASE = 32'hFA00_0000;
    localparam logic [31:0] QSPI_BASE = 32'hFC00_0000;
    localparam logic [31:0] QSPI_BACKED_END = 32'hFE00_0000;
    localparam logic [31:0] RAMH_BASE = 32'hFFFC_0000;
    // target codes, one-hot select bit n stands for code n but is decoded apart
    typedef enum logic [3:0] {
        SAD_T_DRAM = 4'h0,
        SAD_T_FAB0 = 4'h1,
        SAD_T_FAB1 = 4'h2,
        SAD_T_IO = 4'h3,
        SAD_T_APB = 4'h4,
        SAD_T_QSPI = 4'h5,
        SAD_T_RAMH = 4'h6,
        SAD_T_ERR = 4'h7
    } sad_tgt_e;
    localparam int N_TGT = 8;
endpackage

// >>> hdl/sad_dec_if.sv
// address and decode result carried between decoder modules
`timescale 1ns/10ps
`default_nettype none
interface sad_dec_if;
    logic [31:0] addr;
    logic high_ram;
    logic [3:0] tgt;
    modport lookup(input addr, input high_ram, output tgt);
    modport user(output addr, output high_ram, input tgt);
endinterface
`default_nettype wire

// >>> hdl/sad_lookup.sv
// combinational region lookup for one address
`timescale 1ns/10ps
`default_nettype none
module sad_lookup (
    sad_dec_if.lookup dec
);
    import sad_pkg::*;
    sad_tgt_e t;
    // ordered compare from the top of the map down
    always_comb begin
        if (dec.addr >= RAMH_BASE) begin
            // top block errors while the ram is not mapped high
            t = dec.high_ram ? SAD_T_RAMH : SAD_T_ERR;
        end else if (dec.addr >= QSPI_BACKED_END) begin
            t = SAD_T_ERR;
        end else if (dec.addr >= QSPI_BASE) begin
            t = SAD_T_QSPI;
        end else if (dec.addr >= RSV1_BASE) begin
            t = SAD_T_ERR;
        end else if (dec.addr >= APB_BASE) begin
            t = SAD_T_APB;
        end else if (dec.addr >= RSV0_BASE) begin
            t = SAD_T_ERR;
        end else if (dec.addr >= IO_BASE) begin
            t = SAD_T_IO;
        end else if (dec.addr >= HOLE0_BASE) begin
            t = SAD_T_ERR;
        end else if (dec.addr >= FAB1_BASE) begin
            t = SAD_T_FAB1;
        end else if (dec.addr >= FAB0_BASE) begin
            t = SAD_T_FAB0;
        end else begin
            t = SAD_T_DRAM;
        end
    end
    assign dec.tgt = t;
endmodule
`default_nettype wire

// >>> hdl/sad_top.sv
// system address decoder: registered target select and error flag
`timescale 1ns/10ps
`default_nettype none
module sad_top (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire logic [31:0] req_addr_i,
    input wire logic high_ram_i,
    output logic dec_valid_o,
    output logic [31:0] dec_addr_o,
    output logic [7:0] dec_sel_o,
    output logic [3:0] dec_tgt_o,
    output logic dec_err_o
);
    import sad_pkg::*;

    // carrier between this module and the region lookup,
    // address and ram placement out, target code back
    sad_dec_if dec();

    // lookup result and request strobe
    sad_tgt_e tgt_d;
    logic take;

    // region hits straight from the address, kept apart from
    // the lookup so select and code come from two decodes
    logic hit_dram;
    logic hit_fab0;
    logic hit_fab1;
    logic hit_hole;
    logic hit_io;
    logic hit_rsv_lo;
    logic hit_apb;
    logic hit_rsv_hi;
    logic hit_qspi;
    logic hit_gap;
    logic hit_top;

    // next select and error flag
    logic [7:0] sel_d;
    logic err_d;

    // registered decision, one flop group per output
    logic valid_q;
    logic [31:0] addr_q;
    logic [7:0] sel_q;
    logic [3:0] tgt_q;
    logic err_q;

    // request address and ram placement into the carrier
    assign dec.addr = req_addr_i;
    assign dec.high_ram = high_ram_i;

    // ordered compare from the top of the map down,
    // first match wins so overlapping bases cannot clash
    sad_lookup u_lookup (
        .dec(dec)
    );

    // lookup code seen as a target
    assign tgt_d = sad_tgt_e'(dec.tgt);

    // a request counts only on an enabled edge;
    // a low enable drops it rather than queueing it
    assign take = ce_i & req_valid_i;

    // dynamic memory and low on-chip ram,
    // everything below the first fabric port,
    // from address zero up
    assign hit_dram = (req_addr_i < FAB0_BASE);

    // first fabric slave port,
    // the second quarter of the space,
    // up to the next fabric base
    assign hit_fab0 = (req_addr_i >= FAB0_BASE)
        && (req_addr_i < FAB1_BASE);

    // second fabric slave port,
    // the third quarter of the space,
    // up to the undecoded hole
    assign hit_fab1 = (req_addr_i >= FAB1_BASE)
        && (req_addr_i < HOLE0_BASE);

    // undecoded span above the fabric ports,
    // nothing answers here,
    // so it takes the error response
    assign hit_hole = (req_addr_i >= HOLE0_BASE)
        && (req_addr_i < IO_BASE);

    // io peripheral group,
    // one 256 MB span,
    // below the first reserved span
    assign hit_io = (req_addr_i >= IO_BASE)
        && (req_addr_i < RSV0_BASE);

    // lower reserved span,
    // nothing behind it,
    // answered with an error
    assign hit_rsv_lo = (req_addr_i >= RSV0_BASE)
        && (req_addr_i < APB_BASE);

    // register bus window,
    // system registers behind it,
    // 32 MB wide
    assign hit_apb = (req_addr_i >= APB_BASE)
        && (req_addr_i < RSV1_BASE);

    // upper reserved span,
    // nothing behind it,
    // answered with an error
    assign hit_rsv_hi = (req_addr_i >= RSV1_BASE)
        && (req_addr_i < QSPI_BASE);

    // quad-SPI linear window,
    // only the backed lower half,
    // reads go to the flash
    assign hit_qspi = (req_addr_i >= QSPI_BASE)
        && (req_addr_i < QSPI_BACKED_END);

    // unbacked upper half of the flash window,
    // no flash behind it,
    // so it takes the error response
    assign hit_gap = (req_addr_i >= QSPI_BACKED_END)
        && (req_addr_i < RAMH_BASE);

    // topmost block, cut out of the top of the flash window,
    // the on-chip ram when it is mapped high,
    // an error otherwise
    assign hit_top = (req_addr_i >= RAMH_BASE);

    // error response: holes, reserved spans, unbacked flash,
    // and the top block while the ram sits low
    assign err_d = hit_hole | hit_rsv_lo | hit_rsv_hi | hit_gap
        | (hit_top & ~high_ram_i);

    // one-hot select, one bit per target code;
    // the hits are disjoint, so exactly one bit is set
    always_comb begin
        sel_d = 8'h00;
        sel_d[0] = hit_dram;
        sel_d[1] = hit_fab0;
        sel_d[2] = hit_fab1;
        sel_d[3] = hit_io;
        sel_d[4] = hit_apb;
        sel_d[5] = hit_qspi;
        sel_d[6] = hit_top & high_ram_i;
        sel_d[7] = err_d;
    end

    // answer strobe, high one cycle per taken request;
    // a low enable holds it,
    // so a frozen answer stays visible
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            valid_q <= 1'b0;
        end else if (ce_i) begin
            valid_q <= req_valid_i;
        end else begin
            valid_q <= valid_q;
        end
    end

    // copy of the taken address,
    // held until the next taken request,
    // so the master can match the answer
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            addr_q <= 32'h0000_0000;
        end else if (take) begin
            addr_q <= req_addr_i;
        end else begin
            addr_q <= addr_q;
        end
    end

    // one-hot target select,
    // held with the address,
    // exactly one bit after a taken request
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            sel_q <= 8'h00;
        end else if (take) begin
            sel_q <= sel_d;
        end else begin
            sel_q <= sel_q;
        end
    end

    // target code from the ordered lookup,
    // held with the address,
    // zero out of reset
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            tgt_q <= 4'h0;
        end else if (take) begin
            tgt_q <= tgt_d;
        end else begin
            tgt_q <= tgt_q;
        end
    end

    // error flag for the interconnect,
    // which turns it into an error response,
    // held with the address
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            err_q <= 1'b0;
        end else if (take) begin
            err_q <= err_d;
        end else begin
            err_q <= err_q;
        end
    end

    // outputs straight from the flops,
    // no logic between a flop and its pin
    assign dec_valid_o = valid_q;
    assign dec_addr_o = addr_q;
    assign dec_sel_o = sel_q;
    assign dec_tgt_o = tgt_q;
    assign dec_err_o = err_q;
endmodule
`default_nettype wire

// >>> dv/sad_master.sv
// bus master model issuing single decode requests
`timescale 1ns/10ps
`default_nettype none
module sad_master (
    input wire logic c_i,
    output logic [33:0] r_o = 34'h0_0000_0000
);
    // one bus cycle: valid, ram-high flag, address
    task automatic put(input logic v, input logic h, input logic [31:0] x);
        @(posedge c_i) r_o <= {v, h, x};
    endtask
    // single request, then idle bus with inverted address
    task automatic issue(input logic h, input logic [31:0] x);
        put(1'b1, h, x);
        put(1'b0, h, ~x);
    endtask
endmodule
`default_nettype wire

// >>> dv/sad_asserts.sv
// port assertions for the system address decoder
`timescale 1ns/10ps
`default_nettype none
module sad_asserts (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire logic [31:0] req_addr_i,
    input wire logic high_ram_i,
    input wire logic dec_valid_o,
    input wire logic [3:0] dec_tgt_o,
    input wire logic [7:0] dec_sel_o,
    input wire logic dec_err_o,
    input wire logic [31:0] dec_addr_o
);
    wire logic d = dec_valid_o;
    wire logic [3:0] t = dec_tgt_o;
    wire logic [31:0] a = dec_addr_o;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    sequence s_take; ce_i && req_valid_i; endsequence
    sequence s_top; s_take ##0 (&req_addr_i[31:18]); endsequence
    property p_v; s_take |=> d; endproperty
    a_v: assert property (p_v) else $error("no answer");
    property p_a; s_take |=> a == $past(req_addr_i); endproperty
    a_a: assert property (p_a) else $error("address copy");
    property p_e; d |-> dec_err_o == (t == 4'h7); endproperty
    a_e: assert property (p_e) else $error("error flag");
    property p_u; d && a[31:29] == 3'h6 |-> t == 4'h7; endproperty
    a_u: assert property (p_u) else $error("hole");
    property p_x; d && a[31:27] == 5'h1E |-> t == 4'h7; endproperty
    a_x: assert property (p_x) else $error("low reserved");
    property p_y; d && a[31:25] == 7'h7D |-> t == 4'h7; endproperty
    a_y: assert property (p_y) else $error("high reserved");
    property p_n; d && a[31:25] == 7'h7F && !(&a[31:18]) |-> t == 4'h7;
    endproperty
    a_n: assert property (p_n) else $error("unbacked flash");
    property p_s; d |-> dec_sel_o == 8'h01 << t; endproperty
    a_s: assert property (p_s) else $error("select");
    property p_l; d && !a[31] |-> t == a[31:30]; endproperty
    a_l: assert property (p_l) else $error("low");
    property p_f; d && a[31:30] == 2'h2 |-> t == 4'h2; endproperty
    a_f: assert property (p_f) else $error("fabric");
    property p_i; d && a[31:28] == 4'hE |-> t == 4'h3; endproperty
    a_i: assert property (p_i) else $error("io");
    property p_r; d && a[31:25] == 7'h7C |-> t == 4'h4; endproperty
    a_r: assert property (p_r) else $error("regs");
    property p_q; d && a[31:25] == 7'h7E |-> t == 4'h5; endproperty
    a_q: assert property (p_q) else $error("flash");
    property p_h; s_top |=> t == ($past(high_ram_i) ? 4'h6 : 4'h7);
    endproperty
    a_h: assert property (p_h) else $error("high");
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// testbench for the system address decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    wire logic [33:0] r;
    wire logic [45:0] o;
    int bad_count = 0;
    int comparisons = 0;
    sad_top uut (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .req_valid_i(r[33]),
        .high_ram_i(r[32]),
        .req_addr_i(r[31:0]),
        .dec_valid_o(o[45]),
        .dec_tgt_o(o[44:41]),
        .dec_sel_o(o[40:33]),
        .dec_err_o(o[32]),
        .dec_addr_o(o[31:0])
    );
    sad_master m (
        .c_i(clk_sys_i),
        .r_o(r)
    );
    initial forever #12.5 clk_sys_i = ~clk_sys_i;
    task automatic give_verdict;
        if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // whole output word against the expected value
    task automatic cmp_word(input string n, input logic [45:0] e);
        comparisons++;
        if (o !== e) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", n, e, o);
        end
    endtask
    // answer word: valid, code, one-hot select, error, address
    function automatic logic [45:0] ans(input logic [3:0] c,
            input logic [31:0] x);
        return {1'b1, c, 8'h01 << c, c == 4'h7, x};
    endfunction
    // entries: ram-high flag, expected code, upper address half
    task automatic t_map;
        logic [23:0] tv [15] = '{24'h10_3FFF, 24'h11_4000, 24'h12_BFFF,
            24'h17_C000, 24'h13_E000, 24'h17_F000, 24'h14_F800,
            24'h17_FA00, 24'h15_FC00, 24'h15_FDFF, 24'h17_FE00,
            24'h17_FFFB, 24'h16_FFFC, 24'h07_FFFC, 24'h00_0000};
        logic [3:0] c;
        logic [31:0] a;
        foreach (tv[i]) begin
            c = tv[i][19:16];
            a = {tv[i][15:0], 16'h0000};
            m.issue(tv[i][20], a);
            #1 cmp_word("map", ans(c, a));
        end
    endtask
    // valid for one cycle, the rest held
    task automatic t_stand;
        logic [45:0] e;
        e = ans(4'h2, 32'h8000_0000);
        m.issue(1'b0, 32'h8000_0000);
        #1 cmp_word("answer", e);
        e[45] = 1'b0;
        @(posedge clk_sys_i);
        #1 cmp_word("held", e);
    endtask
    // two requests on consecutive edges
    task automatic t_b2b;
        m.put(1'b1, 1'b0, 32'h4000_0004);
        m.put(1'b1, 1'b0, 32'hF800_0010);
        #1 cmp_word("first", ans(4'h1, 32'h4000_0004));
        m.put(1'b0, 1'b0, 32'h07FF_FFEF);
        #1 cmp_word("second", ans(4'h4, 32'hF800_0010));
    endtask
    // low enable freezes a standing answer and drops the next request
    task automatic t_freeze;
        m.put(1'b1, 1'b1, 32'hFFFC_0100);
        m.put(1'b1, 1'b1, 32'hE000_0000);
        ce_i <= 1'b0;
        m.put(1'b0, 1'b1, 32'h1FFF_FFFF);
        #1 cmp_word("freeze", ans(4'h6, 32'hFFFC_0100));
        @(posedge clk_sys_i) ce_i <= 1'b1;
    endtask
    // reset in mid-run clears outputs, then a request at once
    task automatic t_reset;
        m.issue(1'b0, 32'hF000_0000);
        #1 cmp_word("before reset", ans(4'h7, 32'hF000_0000));
        @(posedge clk_sys_i) srst_i <= 1'b1;
        @(posedge clk_sys_i) srst_i <= 1'b0;
        #1 cmp_word("mid reset", 46'h0000_0000_0000);
        m.issue(1'b1, 32'hFFFC_0000);
        #1 cmp_word("after reset", ans(4'h6, 32'hFFFC_0000));
    endtask
    initial begin
        repeat (8) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        #1 cmp_word("reset", 46'h0000_0000_0000);
        t_map;
        t_stand;
        t_b2b;
        t_freeze;
        t_reset;
        give_verdict;
    end
endmodule
bind sad_top sad_asserts chk (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .req_valid_i(req_valid_i),
    .req_addr_i(req_addr_i),
    .high_ram_i(high_ram_i),
    .dec_valid_o(dec_valid_o),
    .dec_tgt_o(dec_tgt_o),
    .dec_sel_o(dec_sel_o),
    .dec_err_o(dec_err_o),
    .dec_addr_o(dec_addr_o)
);
`default_nettype wire
